// *** src/vpf_regs.svh ***
/*
 * vpf_regs.svh: sizes, partition figures and widths of the shared video port fifo.
 * Assumes it is included by its bare name before any module that uses it.
 */
// How it works
// - whole port captures or displays, never mixed
// - one 5120-byte store split by mode
// - capture event when held words reach threshold
// - display event when free words reach threshold
// - dual bt656 capture: A low half, B high half
// - bt656 splits each channel into Y/Cb/Cr
// - raw8 capture: one buffer per channel
// - transport capture like raw8, B disabled
// - y/c: Y low half, chroma split Cb/Cr
// - raw16: one buffer of 16-bit words
// - capture modes: dual 8-bit, single 8/16-bit
// - display modes incl. locked dual raw8
// - channel B idle in single-channel modes
// - three events per channel or one per channel
`ifndef VPF_REGS_SVH
`define VPF_REGS_SVH
`define VPF_FIFO_BYTES 5120
`define VPF_NSLOT 6
`define VPF_SZ_FULL 11'h500
`define VPF_SZ_HALF 11'h280
`define VPF_SZ_QTR 11'h140
`define VPF_SZ_EIGHTH 11'h0a0
`define VPF_SLOTS_BT2 6'h3f
`define VPF_SLOTS_ONE3 6'h07
`define VPF_SLOTS_DUAL1 6'h09
`define VPF_SLOTS_ONE1 6'h01
`endif

// *** src/vpf_pkg.sv ***
/*
 * vpf_pkg: mode and sample phase types of the video port fifo.
 * Assumes nothing of its surroundings.
 */
package vpf_pkg;
  typedef enum logic [2:0] {
    VPF_BT656_1 = 3'h0,
    VPF_BT656_2 = 3'h1,
    VPF_RAW8_1 = 3'h2,
    VPF_RAW8_2 = 3'h3,
    VPF_TRANSPORT = 3'h4,
    VPF_YC = 3'h5,
    VPF_RAW16 = 3'h6
  } vpf_mode_t;

  typedef enum logic [1:0] {
    VPF_PH_CB = 2'h0,
    VPF_PH_Y0 = 2'h1,
    VPF_PH_CR = 2'h2,
    VPF_PH_Y1 = 2'h3
  } vpf_phase_t;
endpackage : vpf_pkg

// *** src/vpf_buf.sv ***
/*
 * vpf_buf: pointers, fill count and dma event pacing of one fifo partition.
 * Assumes the caller never pushes past free space nor pops past the count.
 */
module vpf_buf
  import vpf_pkg::*;
#(
  parameter int AW = 13
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic capture_i,
  input wire logic [AW-3:0] size_i,
  input wire logic [AW-3:0] thr_i,
  input wire logic [2:0] push_i,
  input wire logic [2:0] pop_i,
  output logic [AW-1:0] fill_o,
  output logic [AW-1:0] drain_o,
  output logic [AW-1:0] count_o,
  output logic event_o
);
  logic [AW-1:0] fill_ff, nxt_fill, drain_ff, nxt_drain, count_ff, nxt_count, lim, free_b;
  logic [AW-3:0] owed_ff, nxt_owed, metric;
  logic [AW-2:0] need;
  logic event_ff, nxt_event;

  always_comb begin
    lim = {size_i, 2'b00};
    nxt_fill = fill_ff + AW'(push_i);
    if (nxt_fill >= lim) begin
      nxt_fill = nxt_fill - lim;
    end
    nxt_drain = drain_ff + AW'(pop_i);
    if (nxt_drain >= lim) begin
      nxt_drain = nxt_drain - lim;
    end
    nxt_count = count_ff + AW'(push_i) - AW'(pop_i);
    nxt_owed = owed_ff;
    // a claimed word is retired by the dma move it was raised for
    if (owed_ff != '0 && ((capture_i && pop_i == 3'h4) || (!capture_i && push_i == 3'h4))) begin
      nxt_owed = owed_ff - 1'b1;
    end
    free_b = lim - nxt_count;
    metric = capture_i ? nxt_count[AW-1:2] : free_b[AW-1:2];
    need = {1'b0, nxt_owed} + {1'b0, thr_i};
    nxt_event = 1'b0;
    if (thr_i != '0 && {1'b0, metric} >= need) begin
      nxt_event = 1'b1;
      nxt_owed = need[AW-3:0];
    end
    if (clr_i) begin
      nxt_fill = '0;
      nxt_drain = '0;
      nxt_count = '0;
      nxt_owed = '0;
      nxt_event = 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      fill_ff <= '0;
      drain_ff <= '0;
      count_ff <= '0;
      owed_ff <= '0;
      event_ff <= 1'b0;
    end else if (ce_i) begin
      fill_ff <= nxt_fill;
      drain_ff <= nxt_drain;
      count_ff <= nxt_count;
      owed_ff <= nxt_owed;
      event_ff <= nxt_event;
    end
  end

  assign fill_o = fill_ff;
  assign drain_o = drain_ff;
  assign count_o = count_ff;
  assign event_o = event_ff;

  a_count_bound: assert property (@(posedge clk_i) disable iff (rst_i) count_ff <= {size_i, 2'b00})
    else $error("partition count exceeds its size");
  a_event_claims: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && !clr_i && nxt_event) |=> (event_o && owed_ff >= $past(thr_i)))
    else $error("event raised without claiming a threshold");
  a_zero_thr_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && thr_i == '0) |=> !event_o)
    else $error("event raised with zero threshold");
  a_clr_empties: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && clr_i) |=> (count_o == '0 && !event_o))
    else $error("cleared partition not empty");
endmodule : vpf_buf

// *** src/vpf_fifo.sv ***
/*
 * vpf_fifo: shared capture/display fifo of a two-channel video port with
 * per-buffer dma event generation.
 * Assumes pixel clocks, capture enables and data arrive from pins, well below
 * half of clk_i, and that the dma side is synchronous logic on clk_i.
 */
`include "vpf_regs.svh"

module vpf_fifo
  import vpf_pkg::*;
#(
  parameter int BYTES = `VPF_FIFO_BYTES,
  parameter int AW = 13,
  parameter int NS = `VPF_NSLOT
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic port_en_i,
  input wire logic display_i,
  input wire vpf_mode_t mode_i,
  input wire logic [AW-3:0] thr_a_i,
  input wire logic [AW-3:0] thr_b_i,
  input wire logic link_clk_a_i,
  input wire logic link_clk_b_i,
  input wire logic cap_en_a_i,
  input wire logic cap_en_b_i,
  input wire logic [19:0] video_input_bus_i,
  output logic [19:0] video_output_bus_o,
  output logic video_bus_oe_n_o,
  input wire logic [NS-1:0] dma_rd_i,
  input wire logic [NS-1:0] dma_wr_i,
  input wire logic [31:0] dma_wdata_i,
  output logic [31:0] dma_rdata_o,
  output logic dma_rvalid_o,
  output logic [NS-1:0] dma_event_o,
  output logic port_err_o
);
  logic [7:0] mem [0:BYTES-1];
  logic [23:0] sync1_ff, sync2_ff;
  logic [1:0] clkd_ff;
  vpf_phase_t ph_ff [2];
  vpf_phase_t nxt_ph [2];
  logic [19:0] out_ff, nxt_out;
  logic oe_n_ff, nxt_oe_n, err_ff, nxt_err, rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] edge_s, en_s;
  logic [19:0] bus_s;
  logic [NS-1:0] on_v, clr_v;
  logic [AW-3:0] size_w [NS];
  logic [AW-3:0] base_w [NS];
  logic [AW-1:0] fill_b [NS];
  logic [AW-1:0] drain_b [NS];
  logic [AW-1:0] cnt_b [NS];
  logic [AW-1:0] free_b [NS];
  logic [AW-1:0] afill [NS];
  logic [AW-1:0] adrain [NS];
  logic [2:0] push [NS];
  logic [2:0] pop [NS];
  logic [7:0] wb0 [NS];
  logic [7:0] wb1 [NS];
  logic wgnt_v, rgnt_v, dual, cap_go, dsp_go, cap_a;
  int wgnt, rgnt;

  function automatic logic [AW-3:0] slot_size(input vpf_mode_t m, input int k);
    logic [AW-3:0] s;
    s = '0;
    case (m)
      VPF_BT656_2: s = (k == 0 || k == 3) ? `VPF_SZ_QTR : `VPF_SZ_EIGHTH;
      VPF_BT656_1, VPF_YC: s = (k == 0) ? `VPF_SZ_HALF : (k < 3) ? `VPF_SZ_QTR : '0;
      VPF_RAW8_2: s = (k == 0 || k == 3) ? `VPF_SZ_HALF : '0;
      VPF_TRANSPORT: s = (k == 0) ? `VPF_SZ_HALF : '0;
      VPF_RAW8_1, VPF_RAW16: s = (k == 0) ? `VPF_SZ_FULL : '0;
      default: s = '0;
    endcase
    return s;
  endfunction : slot_size

  function automatic logic [NS-1:0] slot_mask(input vpf_mode_t m, input logic disp);
    logic [NS-1:0] v;
    case (m)
      VPF_BT656_2: v = disp ? 6'h00 : `VPF_SLOTS_BT2;
      VPF_BT656_1, VPF_YC: v = `VPF_SLOTS_ONE3;
      VPF_RAW8_2: v = `VPF_SLOTS_DUAL1;
      VPF_TRANSPORT: v = disp ? 6'h00 : `VPF_SLOTS_ONE1;
      VPF_RAW8_1, VPF_RAW16: v = `VPF_SLOTS_ONE1;
      default: v = 6'h00;
    endcase
    return v;
  endfunction : slot_mask

  // bt656 byte order Cb Y Cr Y
  function automatic int bt_slot(input vpf_phase_t p);
    int s;
    case (p)
      VPF_PH_CB: s = 1;
      VPF_PH_CR: s = 2;
      default: s = 0;
    endcase
    return s;
  endfunction : bt_slot

  function automatic vpf_phase_t bt_next(input vpf_phase_t p);
    vpf_phase_t n;
    case (p)
      VPF_PH_CB: n = VPF_PH_Y0;
      VPF_PH_Y0: n = VPF_PH_CR;
      VPF_PH_CR: n = VPF_PH_Y1;
      default: n = VPF_PH_CB;
    endcase
    return n;
  endfunction : bt_next

  // partition map, one shared store
  always_comb begin
    on_v = port_en_i ? slot_mask(mode_i, display_i) : 6'h00;
    clr_v = ~on_v;
    dual = (mode_i == VPF_BT656_2) || (mode_i == VPF_RAW8_2);
    bus_s = sync2_ff[23:4];
    edge_s = sync2_ff[1:0] & ~clkd_ff;
    en_s = sync2_ff[3:2];
    cap_go = ce_i && port_en_i && !display_i;
    dsp_go = ce_i && port_en_i && display_i;
    cap_a = cap_go && edge_s[0] && en_s[0];
    for (int k = 0; k < NS; k++) begin
      size_w[k] = slot_size(mode_i, k);
      base_w[k] = (k == 0) ? '0 : base_w[k-1] + size_w[k-1];
      free_b[k] = {size_w[k], 2'b00} - cnt_b[k];
      afill[k] = {base_w[k], 2'b00} + fill_b[k];
      adrain[k] = {base_w[k], 2'b00} + drain_b[k];
    end
  end

  generate
    for (genvar g = 0; g < NS; g++) begin : g_buf
      vpf_buf #(.AW(AW)) u_buf (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .clr_i(clr_v[g]),
        .capture_i(!display_i),
        .size_i(size_w[g]),
        .thr_i(g < 3 ? thr_a_i : thr_b_i),
        .push_i(push[g]),
        .pop_i(pop[g]),
        .fill_o(fill_b[g]),
        .drain_o(drain_b[g]),
        .count_o(cnt_b[g]),
        .event_o(dma_event_o[g])
      );
    end
  endgenerate

  // link side and dma side of every partition
  always_comb begin
    int s;
    int c;
    logic [7:0] bc;
    s = 0;
    c = 0;
    bc = 8'h00;
    nxt_ph = ph_ff;
    nxt_out = out_ff;
    nxt_err = 1'b0;
    nxt_oe_n = !(port_en_i && display_i);
    nxt_rvalid = 1'b0;
    nxt_rdata = rdata_ff;
    wgnt_v = 1'b0;
    rgnt_v = 1'b0;
    wgnt = 0;
    rgnt = 0;
    for (int k = 0; k < NS; k++) begin
      push[k] = 3'h0;
      pop[k] = 3'h0;
      wb0[k] = 8'h00;
      wb1[k] = 8'h00;
    end
    for (int ch = 0; ch < 2; ch++) begin
      bc = (ch == 1) ? bus_s[19:12] : bus_s[9:2];
      if (!en_s[ch]) begin
        nxt_ph[ch] = VPF_PH_CB;
      end else if (cap_go && edge_s[ch] && (ch == 0 || dual)) begin
        case (mode_i)
          VPF_BT656_1, VPF_BT656_2: begin
            s = ch * 3 + bt_slot(ph_ff[ch]);
            nxt_ph[ch] = bt_next(ph_ff[ch]);
            if (free_b[s] != '0) begin
              push[s] = 3'h1;
              wb0[s] = bc;
            end else begin
              nxt_err = 1'b1;
            end
          end
          VPF_RAW8_1, VPF_RAW8_2, VPF_TRANSPORT: begin
            s = ch * 3;
            if (free_b[s] != '0) begin
              push[s] = 3'h1;
              wb0[s] = bc;
            end else begin
              nxt_err = 1'b1;
            end
          end
          VPF_YC: begin
            c = (ph_ff[0] == VPF_PH_CB) ? 1 : 2;
            nxt_ph[0] = (ph_ff[0] == VPF_PH_CB) ? VPF_PH_CR : VPF_PH_CB;
            if (free_b[0] != '0 && free_b[c] != '0) begin
              push[0] = 3'h1;
              wb0[0] = bus_s[9:2];
              push[c] = 3'h1;
              wb0[c] = bus_s[19:12];
            end else begin
              nxt_err = 1'b1;
            end
          end
          VPF_RAW16: begin
            if (free_b[0] >= 13'h0002) begin
              push[0] = 3'h2;
              wb0[0] = bus_s[9:2];
              wb1[0] = bus_s[19:12];
            end else begin
              nxt_err = 1'b1;
            end
          end
          default: ;
        endcase
      end
    end
    // display: both channels locked to channel A's pixel clock
    if (dsp_go && edge_s[0]) begin
      case (mode_i)
        VPF_BT656_1: begin
          s = bt_slot(ph_ff[0]);
          nxt_ph[0] = bt_next(ph_ff[0]);
          if (cnt_b[s] != '0) begin
            pop[s] = 3'h1;
            nxt_out = {10'h000, mem[adrain[s]], 2'b00};
          end else begin
            nxt_err = 1'b1;
          end
        end
        VPF_RAW8_1, VPF_RAW8_2: begin
          if (cnt_b[0] != '0 && (mode_i == VPF_RAW8_1 || cnt_b[3] != '0)) begin
            pop[0] = 3'h1;
            nxt_out[9:2] = mem[adrain[0]];
            if (mode_i == VPF_RAW8_2) begin
              pop[3] = 3'h1;
              nxt_out[19:12] = mem[adrain[3]];
            end
          end else begin
            nxt_err = 1'b1;
          end
        end
        VPF_YC: begin
          c = (ph_ff[0] == VPF_PH_CB) ? 1 : 2;
          nxt_ph[0] = (ph_ff[0] == VPF_PH_CB) ? VPF_PH_CR : VPF_PH_CB;
          if (cnt_b[0] != '0 && cnt_b[c] != '0) begin
            pop[0] = 3'h1;
            pop[c] = 3'h1;
            nxt_out = {mem[adrain[c]], 2'b00, mem[adrain[0]], 2'b00};
          end else begin
            nxt_err = 1'b1;
          end
        end
        VPF_RAW16: begin
          if (cnt_b[0] >= 13'h0002) begin
            pop[0] = 3'h2;
            nxt_out = {mem[adrain[0] + 13'h0001], 2'b00, mem[adrain[0]], 2'b00};
          end else begin
            nxt_err = 1'b1;
          end
        end
        default: ;
      endcase
    end
    // one dma word per cycle, lowest partition first
    for (int k = NS - 1; k >= 0; k--) begin
      if (cap_go && on_v[k] && dma_rd_i[k] && cnt_b[k] >= 13'h0004) begin
        rgnt_v = 1'b1;
        rgnt = k;
      end
      if (dsp_go && on_v[k] && dma_wr_i[k] && free_b[k] >= 13'h0004) begin
        wgnt_v = 1'b1;
        wgnt = k;
      end
    end
    if (rgnt_v) begin
      pop[rgnt] = 3'h4;
      nxt_rvalid = 1'b1;
      nxt_rdata = {mem[adrain[rgnt] + 13'h0003], mem[adrain[rgnt] + 13'h0002],
        mem[adrain[rgnt] + 13'h0001], mem[adrain[rgnt]]};
    end
    if (wgnt_v) begin
      push[wgnt] = 3'h4;
    end
    if (!ce_i) begin
      for (int k = 0; k < NS; k++) begin
        push[k] = 3'h0;
        pop[k] = 3'h0;
      end
    end
    if (display_i || !port_en_i) begin
      nxt_out = port_en_i ? nxt_out : 20'h00000;
    end else begin
      nxt_out = 20'h00000;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_ff <= 24'h000000;
      sync2_ff <= 24'h000000;
      clkd_ff <= 2'h0;
      ph_ff[0] <= VPF_PH_CB;
      ph_ff[1] <= VPF_PH_CB;
      out_ff <= 20'h00000;
      oe_n_ff <= 1'b1;
      err_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else if (ce_i) begin
      sync1_ff <= {video_input_bus_i, cap_en_b_i, cap_en_a_i, link_clk_b_i, link_clk_a_i};
      sync2_ff <= sync1_ff;
      clkd_ff <= sync2_ff[1:0];
      ph_ff <= nxt_ph;
      out_ff <= nxt_out;
      oe_n_ff <= nxt_oe_n;
      err_ff <= nxt_err;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
    end
  end

  // shared store, no reset needed for data
  always_ff @(posedge clk_i) begin
    for (int k = 0; k < NS; k++) begin
      if (push[k] == 3'h1 || push[k] == 3'h2) begin
        mem[afill[k]] <= wb0[k];
      end
      if (push[k] == 3'h2) begin
        mem[afill[k] + 13'h0001] <= wb1[k];
      end
    end
    if (ce_i && wgnt_v) begin
      for (int b = 0; b < 4; b++) begin
        mem[afill[wgnt] + AW'(b)] <= dma_wdata_i[8*b +: 8];
      end
    end
  end

  assign video_output_bus_o = out_ff;
  assign video_bus_oe_n_o = oe_n_ff;
  assign dma_rdata_o = rdata_ff;
  assign dma_rvalid_o = rvalid_ff;
  assign port_err_o = err_ff;

  a_oe_follows_dir: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && port_en_i) |=> (video_bus_oe_n_o == !$past(display_i)))
    else $error("pin direction does not follow port direction");
  a_b_idle_single: assert property (@(posedge clk_i) disable iff (rst_i)
    !dual |-> ((push[3] | push[4] | push[5] | pop[3] | pop[4] | pop[5]) == 3'h0))
    else $error("channel B active in single-channel mode");
  a_bt_b_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (cap_go && mode_i == VPF_BT656_2 && edge_s[1] && en_s[1])
      |-> ((push[3] | push[4] | push[5]) == 3'h1 || nxt_err))
    else $error("bt656 channel B sample not stored");
  a_yc_split: assert property (@(posedge clk_i) disable iff (rst_i)
    (cap_a && mode_i == VPF_YC) |-> ((push[0] == 3'h1 && (push[1] ^ push[2]) == 3'h1) || nxt_err))
    else $error("y/c sample not split into luma and one chroma");
  a_raw16_word: assert property (@(posedge clk_i) disable iff (rst_i)
    (cap_a && mode_i == VPF_RAW16) |-> (push[0] == 3'h2 || nxt_err))
    else $error("raw16 sample not stored as two bytes");
  a_event_mask: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i |=> ((dma_event_o & ~$past(on_v)) == 6'h00))
    else $error("event on an unused partition");
  a_read_answer: assert property (@(posedge clk_i) disable iff (rst_i)
    (ce_i && rgnt_v) |=> (dma_rvalid_o && dma_rdata_o == $past(nxt_rdata)))
    else $error("granted read not answered");
  c_dual_bt_event: cover property (@(posedge clk_i) disable iff (rst_i)
    mode_i == VPF_BT656_2 && dma_event_o[4]);
  c_display_pop: cover property (@(posedge clk_i) disable iff (rst_i) dsp_go && pop[0] != 3'h0);
  c_raw16_read: cover property (@(posedge clk_i) disable iff (rst_i) mode_i == VPF_RAW16 && rgnt_v);
endmodule : vpf_fifo

// *** tb/vpf_dma_model.sv ***
/*
 * vpf_dma_model: behavioural dma controller that serves the fifo's transfer requests.
 * Assumes event pulses, read strobes and read answers on clk_i as the fifo's contract sets them.
 */
module vpf_dma_model
  import vpf_pkg::*;
#(
  parameter int NS = 6
) (
  input wire logic clk_i,
  input wire logic display_i,
  input wire logic slow_i,
  input wire logic [10:0] thr_a_i,
  input wire logic [10:0] thr_b_i,
  input wire logic [NS-1:0] dma_event_i,
  input wire logic [31:0] dma_rdata_i,
  input wire logic dma_rvalid_i,
  output logic [NS-1:0] dma_rd_o,
  output logic [NS-1:0] dma_wr_o,
  output logic [31:0] dma_wdata_o
);
  timeunit 1ns;
  timeprecision 100ps;
  int pend_q[$];
  logic [34:0] got_q[$];
  logic [7:0] wbyte;
  int k;
  int n;

  always @(posedge clk_i) begin
    for (int i = 0; i < NS; i++) begin
      if (dma_event_i[i] === 1'b1) begin
        pend_q.push_back(i);
      end
    end
  end

  initial begin
    dma_rd_o = '0;
    dma_wr_o = '0;
    dma_wdata_o = 32'h5a5a5a5a;
    wbyte = 8'h00;
    forever begin
      @(posedge clk_i);
      if (pend_q.size() > 0) begin
        k = pend_q.pop_front();
        // fixed size per request: exactly thr words
        n = (k < 3) ? int'(thr_a_i) : int'(thr_b_i);
        for (int j = 0; j < n; j++) begin
          @(negedge clk_i);
          if (display_i) begin
            dma_wr_o[k] = 1'b1;
            dma_wdata_o = {8'(wbyte + 3), 8'(wbyte + 2), 8'(wbyte + 1), wbyte};
            wbyte = wbyte + 8'h04;
          end else begin
            dma_rd_o[k] = 1'b1;
          end
          @(posedge clk_i);
          @(negedge clk_i);
          dma_rd_o = '0;
          dma_wr_o = '0;
          // released data lines do not keep the last word
          dma_wdata_o = ~dma_wdata_o;
          if (!display_i) begin
            // read answer stands from the grant edge to the next one
            got_q.push_back({k[2:0], (dma_rvalid_i === 1'b1) ? dma_rdata_i : 32'hdeaddead});
          end
          if (slow_i) begin
            repeat (5) @(posedge clk_i);
          end
        end
      end
    end
  end
endmodule : vpf_dma_model

// *** tb/tb_top.sv ***
/*
 * tb_top: self-checking bench of the video port fifo with a dma model on its far side.
 * Assumes the fifo's contract: pin clocks seen through two sync stages, one-cycle pulses.
 */
module tb_top
  import vpf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i, rst_i, port_en, display, lclk_a, lclk_b, cap_a, cap_b, oe_n, rvalid, err, slow;
  vpf_mode_t mode;
  logic [10:0] thr_a, thr_b;
  logic [19:0] vin, vout;
  logic [5:0] rd, wr, ev;
  logic [31:0] wdata, rdata;
  int err_count, checks, cyc, fault_cnt;
  int ev_cnt[6];

  vpf_fifo vpf_fifo_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .port_en_i(port_en),
    .display_i(display), .mode_i(mode), .thr_a_i(thr_a), .thr_b_i(thr_b), .link_clk_a_i(lclk_a),
    .link_clk_b_i(lclk_b), .cap_en_a_i(cap_a), .cap_en_b_i(cap_b), .video_input_bus_i(vin),
    .video_output_bus_o(vout), .video_bus_oe_n_o(oe_n), .dma_rd_i(rd), .dma_wr_i(wr),
    .dma_wdata_i(wdata), .dma_rdata_o(rdata), .dma_rvalid_o(rvalid), .dma_event_o(ev),
    .port_err_o(err));
  vpf_dma_model vpf_dma_model_inst (.clk_i(clk_i), .display_i(display), .slow_i(slow),
    .thr_a_i(thr_a), .thr_b_i(thr_b), .dma_event_i(ev), .dma_rdata_i(rdata),
    .dma_rvalid_i(rvalid), .dma_rd_o(rd), .dma_wr_o(wr), .dma_wdata_o(wdata));

  always #2 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    for (int i = 0; i < 6; i++) begin
      if (ev[i] === 1'b1) begin
        ev_cnt[i]++;
      end
    end
    if (err === 1'b1) begin
      fault_cnt++;
    end
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  function automatic logic [31:0] w4(input logic [7:0] b, input logic [7:0] s);
    return {8'(b + 3 * s), 8'(b + 2 * s), 8'(b + s), b};
  endfunction : w4

  // finds one read word of a partition in any order and retires it
  task automatic expect_word(input logic [2:0] p, input logic [31:0] w);
    int idx;
    idx = -1;
    foreach (vpf_dma_model_inst.got_q[i]) begin
      if (vpf_dma_model_inst.got_q[i] === {p, w}) idx = i;
    end
    checks++;
    if (idx < 0) begin
      err_count++;
      $display("ERROR read word of part %0d expected %h seen none", p, w);
    end else begin
      vpf_dma_model_inst.got_q.delete(idx);
    end
  endtask : expect_word

  task automatic cfg(input vpf_mode_t m, input logic disp, input logic [10:0] ta, input logic [10:0] tb);
    @(negedge clk_i);
    port_en = 1'b0;
    cap_a = 1'b0;
    cap_b = 1'b0;
    repeat (4) @(negedge clk_i);
    mode = m;
    display = disp;
    thr_a = ta;
    thr_b = tb;
    for (int i = 0; i < 6; i++) ev_cnt[i] = 0;
    fault_cnt = 0;
    vpf_dma_model_inst.got_q.delete();
    @(negedge clk_i);
    port_en = 1'b1;
    cap_a = 1'b1;
    cap_b = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask : cfg

  // one pixel per 164 ns pin clock, data counting up from the bases
  task automatic send(input int n, input logic [7:0] lo, input logic [7:0] hi, input logic on_b);
    for (int i = 0; i < n; i++) begin
      @(negedge clk_i);
      vin = {8'(hi + i), 2'b00, 8'(lo + i), 2'b00};
      if (on_b) lclk_b = 1'b1;
      else lclk_a = 1'b1;
      repeat (20) @(negedge clk_i);
      lclk_a = 1'b0;
      lclk_b = 1'b0;
      repeat (20) @(negedge clk_i);
    end
    vin = ~vin;
    repeat (40) @(negedge clk_i);
  endtask : send

  task automatic t_reset();
    chk("oe_n after reset", 32'h1, 32'(oe_n));
    chk("event after reset", 32'h0, 32'(ev));
    chk("rvalid after reset", 32'h0, 32'(rvalid));
    chk("output bus after reset", 32'h0, 32'(vout));
    chk("port error after reset", 32'h0, 32'(err));
  endtask : t_reset

  task automatic t_raw8();
    cfg(VPF_RAW8_1, 1'b0, 11'h002, 11'h002);
    send(4, 8'h10, 8'hc0, 1'b0);
    chk("raw8 events below threshold", 32'h0, ev_cnt[0]);
    send(4, 8'h14, 8'hc4, 1'b0);
    chk("raw8 events at threshold", 32'h1, ev_cnt[0]);
    expect_word(3'h0, w4(8'h10, 8'h01));
    expect_word(3'h0, w4(8'h14, 8'h01));
    chk("raw8 stray words", 32'h0, vpf_dma_model_inst.got_q.size());
    chk("raw8 overrun pulses", 32'h0, fault_cnt);
  endtask : t_raw8

  task automatic t_dual();
    cfg(VPF_RAW8_2, 1'b0, 11'h001, 11'h001);
    send(4, 8'h20, 8'h40, 1'b1);
    send(4, 8'h30, 8'h50, 1'b0);
    expect_word(3'h3, w4(8'h40, 8'h01));
    expect_word(3'h0, w4(8'h30, 8'h01));
    chk("dual stray words", 32'h0, vpf_dma_model_inst.got_q.size());
  endtask : t_dual

  task automatic t_transport();
    cfg(VPF_TRANSPORT, 1'b0, 11'h001, 11'h001);
    send(4, 8'h20, 8'h40, 1'b1);
    chk("transport B events", 32'h0, ev_cnt[3]);
    send(4, 8'h60, 8'h70, 1'b0);
    expect_word(3'h0, w4(8'h60, 8'h01));
    chk("transport stray words", 32'h0, vpf_dma_model_inst.got_q.size());
  endtask : t_transport

  task automatic t_bt();
    logic [7:0] b;
    cfg(VPF_BT656_1, 1'b0, 11'h001, 11'h001);
    send(16, 8'h00, 8'h00, 1'b1);
    chk("bt656 single B words", 32'h0, vpf_dma_model_inst.got_q.size());
    cfg(VPF_BT656_2, 1'b0, 11'h001, 11'h001);
    send(16, 8'h00, 8'ha0, 1'b0);
    send(16, 8'h00, 8'ha0, 1'b1);
    for (int c = 0; c < 2; c++) begin
      b = (c == 1) ? 8'ha0 : 8'h00;
      expect_word(3'(3 * c), w4(8'(b + 1), 8'h02));
      expect_word(3'(3 * c), w4(8'(b + 9), 8'h02));
      expect_word(3'(3 * c + 1), w4(b, 8'h04));
      expect_word(3'(3 * c + 2), w4(8'(b + 2), 8'h04));
      chk("bt656 luma events", 32'h2, ev_cnt[3 * c]);
      chk("bt656 cb events", 32'h1, ev_cnt[3 * c + 1]);
      chk("bt656 cr events", 32'h1, ev_cnt[3 * c + 2]);
    end
  endtask : t_bt

  task automatic t_yc();
    cfg(VPF_YC, 1'b0, 11'h001, 11'h001);
    send(8, 8'h20, 8'h80, 1'b0);
    expect_word(3'h0, w4(8'h20, 8'h01));
    expect_word(3'h0, w4(8'h24, 8'h01));
    expect_word(3'h1, w4(8'h80, 8'h02));
    expect_word(3'h2, w4(8'h81, 8'h02));
    chk("y/c B events", 32'h0, ev_cnt[3] + ev_cnt[4] + ev_cnt[5]);
  endtask : t_yc

  task automatic t_raw16();
    cfg(VPF_RAW16, 1'b0, 11'h001, 11'h001);
    send(2, 8'h30, 8'h50, 1'b0);
    expect_word(3'h0, 32'h51315030);
    chk("raw16 stray words", 32'h0, vpf_dma_model_inst.got_q.size());
  endtask : t_raw16

  task automatic t_disp();
    cfg(VPF_RAW8_1, 1'b1, 11'h000, 11'h000);
    send(1, 8'h00, 8'h00, 1'b0);
    chk("display underrun pulses", 32'h1, fault_cnt);
    chk("display output on underrun", 32'h0, 32'(vout));
    slow = 1'b1;
    cfg(VPF_RAW8_1, 1'b1, 11'h040, 11'h040);
    repeat (200) @(negedge clk_i);
    chk("display drives pins", 32'h0, 32'(oe_n));
    chk("display events on free space", 32'd20, ev_cnt[0]);
    for (int i = 0; i < 8; i++) begin
      lclk_a = 1'b1;
      repeat (20) @(negedge clk_i);
      chk("display output byte", {22'h000000, 8'(i), 2'b00}, 32'(vout));
      lclk_a = 1'b0;
      repeat (20) @(negedge clk_i);
    end
    chk("display events after pops", 32'd20, ev_cnt[0]);
    chk("display pops without underrun", 32'h0, fault_cnt);
  endtask : t_disp

  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    port_en = 1'b0;
    display = 1'b0;
    mode = VPF_RAW8_1;
    thr_a = 11'h000;
    thr_b = 11'h000;
    lclk_a = 1'b0;
    lclk_b = 1'b0;
    cap_a = 1'b0;
    cap_b = 1'b0;
    vin = 20'h00000;
    slow = 1'b0;
    err_count = 0;
    checks = 0;
    cyc = 0;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_reset();
    t_raw8();
    t_dual();
    t_transport();
    t_bt();
    t_yc();
    t_raw16();
    t_disp();
    wrap_up();
  end
endmodule : tb_top
